/* hw/hbfc_pkg.sv */
package hbfc_pkg;

  // ********
  // Timing
  // ********
  localparam int unsigned CLK_PERIOD_NS     = 25;
  localparam int unsigned PWM_STALL_TIME_NS = 100_000;
  // A least time, so round up to whole cycles
  localparam int unsigned PWM_STALL_CYCLES  = (PWM_STALL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STALL_CNT_W       = 12;

  // ********
  // Temperature thresholds, degrees C as sensor code
  // ********
  localparam logic [7:0] TEMP_SHUTDOWN_C = 8'h96;  // 150
  localparam logic [7:0] TEMP_WARN_C     = 8'h7D;  // 125

  // ********
  // Register map
  // ********
  localparam int unsigned  ADDR_W      = 8;
  localparam logic [7:0]   OFS_CTRL    = 8'h00;
  localparam logic [7:0]   OFS_STATE   = 8'h04;
  localparam logic [7:0]   OFS_IRQ_ST  = 8'h08;
  localparam logic [7:0]   OFS_IRQ_MSK = 8'h0C;
  localparam logic [7:0]   OFS_LINES   = 8'h10;

  localparam int unsigned  CTRL_MUTE_BIT = 0;
  localparam logic         CTRL_MUTE_RST = 1'b0;

  // Event bits, shared by status and mask
  localparam int unsigned  EV_SHORT     = 0;
  localparam int unsigned  EV_ILLEGAL   = 1;
  localparam int unsigned  EV_OVERTEMP  = 2;
  localparam int unsigned  EV_UNDERVOLT = 3;
  localparam int unsigned  EV_WARN      = 4;
  localparam int unsigned  EV_W         = 5;
  localparam logic [4:0]   IRQ_ST_RST   = 5'h00;
  localparam logic [4:0]   IRQ_MSK_RST  = 5'h00;

  // State register fields
  localparam int unsigned  ST_CODE_LSB  = 0;  // 3 bits: shutdown, bit1, bit0
  localparam int unsigned  ST_MODE_LSB  = 4;  // 2 bits
  localparam int unsigned  ST_EV_LSB    = 8;  // 5 live condition bits
  localparam int unsigned  ST_PD_N_BIT  = 16;
  localparam int unsigned  ST_RST_N_BIT = 17;

  // ********
  // Types
  // ********
  typedef enum logic [2:0] {
    FC_ILLEGAL   = 3'b000,
    FC_SHORT     = 3'b001,
    FC_OVERTEMP  = 3'b010,
    FC_UNDERVOLT = 3'b011,
    FC_WARN      = 3'b110,
    FC_NORMAL    = 3'b111
  } hbfc_code_type;

  typedef enum logic [1:0] {
    MODE_POWERDOWN = 2'b00,
    MODE_LATCHED   = 2'b01,
    MODE_HOLD_LOW  = 2'b10,
    MODE_RUN       = 2'b11
  } hbfc_mode_type;

endpackage : hbfc_pkg

/* hw/hbfc_fault_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface hbfc_fault_if;
  logic illegal;
  logic stalled;
  logic short_latched;
  logic overtemp;
  logic undervolt;
  logic warn;

  modport pwm_mp   (output illegal, output stalled);
  modport sense_mp (output short_latched, output overtemp, output undervolt, output warn);
  modport top_mp   (input illegal, input stalled, input short_latched, input overtemp,
                    input undervolt, input warn);
endinterface : hbfc_fault_if

`default_nettype wire

/* hw/hbfc_pwm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module hbfc_pwm_monitor
  import hbfc_pkg::*;
(
  input  wire logic       mclk_i,   // System clock
  input  wire logic       nrst_i,   // Sync reset, active low
  input  wire logic       ignore_i, // Device reset or power-down
  input  wire logic [3:0] pwm_i,    // Synced {a_pos, a_neg, b_pos, b_neg}
  hbfc_fault_if.pwm_mp    flt       // Illegal and stalled flags
);

  logic [3:0]             pwm_last_q;
  logic [STALL_CNT_W-1:0] idle_cnt_q;
  logic                   illegal_q;
  logic                   stalled_q;

  assign flt.illegal = illegal_q;
  assign flt.stalled = stalled_q;

  always_ff @(posedge mclk_i) begin
    pwm_last_q <= pwm_i;
  end

  // ********
  // Activity detector
  // ********
  always_ff @(posedge mclk_i) begin
    if (!nrst_i || ignore_i) begin
      idle_cnt_q <= '0;
      stalled_q  <= 1'b0;
    end else if (pwm_i != pwm_last_q) begin
      idle_cnt_q <= '0;
      stalled_q  <= 1'b0;
    end else if (idle_cnt_q == STALL_CNT_W'(PWM_STALL_CYCLES - 1)) begin
      stalled_q  <= 1'b1;
    end else begin
      idle_cnt_q <= idle_cnt_q + STALL_CNT_W'(1);
    end
  end

  // ********
  // Pair legality: 00 and 11 on either half-bridge
  // ********
  always_ff @(posedge mclk_i) begin
    if (!nrst_i || ignore_i) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= (pwm_i[3] == pwm_i[2]) || (pwm_i[1] == pwm_i[0]);
    end
  end

endmodule : hbfc_pwm_monitor

`default_nettype wire

/* hw/hbfc_fault_sense.sv */
`timescale 1ns/1ps
`default_nettype none

module hbfc_fault_sense
  import hbfc_pkg::*;
(
  input  wire logic       mclk_i,     // System clock
  input  wire logic       nrst_i,     // Sync reset, active low
  input  wire logic       dev_rst_n_i,// Synced device reset pin
  input  wire logic       pd_n_i,     // Synced power-down pin
  input  wire logic       overcur_i,  // Synced over-current detect
  input  wire logic [7:0] temp_i,     // Synced junction temperature
  input  wire logic       reg_a_ok_i, // Synced regulator A adequate
  input  wire logic       reg_b_ok_i, // Synced regulator B adequate
  hbfc_fault_if.sense_mp  flt         // Sensed fault flags
);

  logic short_q;
  logic overtemp_q;
  logic undervolt_q;
  logic warn_q;

  assign flt.short_latched = short_q;
  assign flt.overtemp      = overtemp_q;
  assign flt.undervolt     = undervolt_q;
  assign flt.warn          = warn_q;

  // Reset pin clears the latch; while it is held no current flows, so clear wins
  always_ff @(posedge mclk_i) begin
    if (!nrst_i || !dev_rst_n_i) begin
      short_q <= 1'b0;
    end else if (pd_n_i && overcur_i) begin
      short_q <= 1'b1;
    end
  end

  // Hysteresis: set above shutdown level, clear only back at warning level
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      overtemp_q <= 1'b0;
    end else if (temp_i > TEMP_SHUTDOWN_C) begin
      overtemp_q <= 1'b1;
    end else if (temp_i <= TEMP_WARN_C) begin
      overtemp_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      warn_q <= 1'b0;
    end else begin
      warn_q <= temp_i > TEMP_WARN_C;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      undervolt_q <= 1'b0;
    end else begin
      undervolt_q <= !reg_a_ok_i || !reg_b_ok_i;
    end
  end

endmodule : hbfc_fault_sense

`default_nettype wire

/* hw/hbfc_top.sv */
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module hbfc_top
  import hbfc_pkg::*;
(
  input  wire logic              mclk_i,               // 40 MHz clock
  input  wire logic              nrst_i,               // Sync reset, active low
  input  wire logic              power_down_n_i,       // Power-down pin, active low
  input  wire logic              dev_reset_n_i,        // Device reset pin, active low
  input  wire logic              pwm_a_pos_i,          // PWM A(+)
  input  wire logic              pwm_a_neg_i,          // PWM A(-)
  input  wire logic              pwm_b_pos_i,          // PWM B(+)
  input  wire logic              pwm_b_neg_i,          // PWM B(-)
  input  wire logic              overcur_i,            // Over-current sense
  input  wire logic [7:0]        temp_i,               // Junction temperature, degC
  input  wire logic              regulator_out_a_ok_i, // Regulator A adequate
  input  wire logic              regulator_out_b_ok_i, // Regulator B adequate
  output logic                   bridge_out_a_o,       // Bridge A level
  output logic                   bridge_out_a_oe_n_o,  // Bridge A enable, low drives
  output logic                   bridge_out_b_o,       // Bridge B level
  output logic                   bridge_out_b_oe_n_o,  // Bridge B enable, low drives
  input  wire logic              shutdown_n_i,         // Shutdown line readback
  output logic                   shutdown_n_o,         // Shutdown line level (0)
  output logic                   shutdown_n_oe_n_o,    // Low pulls line low
  input  wire logic              fault_code_bit1_i,    // Code bit1 readback
  output logic                   fault_code_bit1_o,    // Code bit1 level (0)
  output logic                   fault_code_bit1_oe_n_o, // Low pulls line low
  input  wire logic              fault_code_bit0_i,    // Code bit0 readback
  output logic                   fault_code_bit0_o,    // Code bit0 level (0)
  output logic                   fault_code_bit0_oe_n_o, // Low pulls line low
  input  wire logic [ADDR_W-1:0] reg_addr_i,           // Register byte address
  input  wire logic [31:0]       reg_wdata_i,          // Write data
  input  wire logic              reg_wr_i,             // Write strobe
  input  wire logic              reg_rd_i,             // Read strobe
  output logic [31:0]            reg_rdata_o,          // Read data, cycle after strobe
  output logic                   irq_o                 // Level interrupt
);

  // ********
  // Pin synchronisers
  // ********
  localparam int unsigned SYNC_W = 20;

  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;
  logic              pd_n;
  logic              dev_rst_n;
  logic [3:0]        pwm;
  logic              overcur;
  logic              reg_a_ok;
  logic              reg_b_ok;
  logic [2:0]        lines;
  logic [7:0]        temp;

  // Temperature is a slow word; the sensor must hold it stable across a sample
  always_ff @(posedge mclk_i) begin
    meta_q <= {power_down_n_i, dev_reset_n_i, pwm_a_pos_i, pwm_a_neg_i, pwm_b_pos_i,
               pwm_b_neg_i, overcur_i, regulator_out_a_ok_i, regulator_out_b_ok_i,
               shutdown_n_i, fault_code_bit1_i, fault_code_bit0_i, temp_i};
    sync_q <= meta_q;
  end

  assign {pd_n, dev_rst_n, pwm, overcur, reg_a_ok, reg_b_ok, lines, temp} = sync_q;

  // ********
  // Fault detectors
  // ********
  hbfc_fault_if flt ();

  hbfc_pwm_monitor u_pwm_monitor (
    .mclk_i   (mclk_i),
    .nrst_i   (nrst_i),
    .ignore_i (!dev_rst_n || !pd_n),
    .pwm_i    (pwm),
    .flt      (flt.pwm_mp)
  );

  hbfc_fault_sense u_fault_sense (
    .mclk_i      (mclk_i),
    .nrst_i      (nrst_i),
    .dev_rst_n_i (dev_rst_n),
    .pd_n_i      (pd_n),
    .overcur_i   (overcur),
    .temp_i      (temp),
    .reg_a_ok_i  (reg_a_ok),
    .reg_b_ok_i  (reg_b_ok),
    .flt         (flt.sense_mp)
  );

  // ********
  // Mode and fault code
  // ********
  logic          mute_q;
  logic          illegal_any;
  hbfc_mode_type mode;
  hbfc_code_type code;

  assign illegal_any = flt.illegal || flt.stalled;

  function automatic hbfc_code_type fault_code(input logic pd_n_f, input logic short_f,
                                               input logic uv_f, input logic ot_f,
                                               input logic ill_f, input logic warn_f);
    if (!pd_n_f) begin
      fault_code = FC_NORMAL;
    end else if (short_f) begin
      fault_code = FC_SHORT;
    end else if (uv_f) begin
      fault_code = FC_UNDERVOLT;
    end else if (ot_f) begin
      fault_code = FC_OVERTEMP;
    end else if (ill_f) begin
      fault_code = FC_ILLEGAL;
    end else if (warn_f) begin
      fault_code = FC_WARN;
    end else begin
      fault_code = FC_NORMAL;
    end
  endfunction : fault_code

  always_comb begin
    code = fault_code(pd_n, flt.short_latched, flt.undervolt, flt.overtemp, illegal_any,
                      flt.warn);
    if (!pd_n) begin
      mode = MODE_POWERDOWN;
    end else if (flt.short_latched) begin
      mode = MODE_LATCHED;
    end else if (!dev_rst_n || mute_q) begin
      mode = MODE_HOLD_LOW;
    end else if (illegal_any || flt.overtemp || flt.undervolt) begin
      mode = MODE_HOLD_LOW;
    end else begin
      mode = MODE_RUN;
    end
  end

  // ********
  // Bridge drivers
  // ********
  logic a_q;
  logic a_oe_n_q;
  logic b_q;
  logic b_oe_n_q;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      a_q      <= 1'b0;
      b_q      <= 1'b0;
      a_oe_n_q <= 1'b1;
      b_oe_n_q <= 1'b1;
    end else begin
      case (mode)
        MODE_POWERDOWN, MODE_LATCHED: begin
          a_q      <= 1'b0;
          b_q      <= 1'b0;
          a_oe_n_q <= 1'b1;
          b_oe_n_q <= 1'b1;
        end
        MODE_RUN: begin
          a_q      <= pwm[3];
          b_q      <= pwm[1];
          a_oe_n_q <= 1'b0;
          b_oe_n_q <= 1'b0;
        end
        default: begin
          a_q      <= 1'b0;
          b_q      <= 1'b0;
          a_oe_n_q <= 1'b0;
          b_oe_n_q <= 1'b0;
        end
      endcase
    end
  end

  assign bridge_out_a_o      = a_q;
  assign bridge_out_a_oe_n_o = a_oe_n_q;
  assign bridge_out_b_o      = b_q;
  assign bridge_out_b_oe_n_o = b_oe_n_q;

  // ********
  // Open-drain fault lines
  // ********
  // Level is always zero; a one bit is expressed only by releasing the line
  logic [2:0] od_level_q;
  logic [2:0] od_oe_n_q;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      od_level_q <= 3'h0;
      od_oe_n_q  <= 3'h7;
    end else begin
      od_level_q <= 3'h0;
      od_oe_n_q  <= code;
    end
  end

  assign shutdown_n_o           = od_level_q[2];
  assign fault_code_bit1_o      = od_level_q[1];
  assign fault_code_bit0_o      = od_level_q[0];
  assign shutdown_n_oe_n_o      = od_oe_n_q[2];
  assign fault_code_bit1_oe_n_o = od_oe_n_q[1];
  assign fault_code_bit0_oe_n_o = od_oe_n_q[0];

  // ********
  // Interrupt events
  // ********
  logic [EV_W-1:0] cond;
  logic [EV_W-1:0] cond_q;
  logic [EV_W-1:0] irq_st_q;
  logic [EV_W-1:0] irq_msk_q;
  logic            irq_q;
  logic            wr_irq_st;

  assign cond = {flt.warn, flt.undervolt, flt.overtemp, illegal_any, flt.short_latched};
  assign wr_irq_st = reg_wr_i && (reg_addr_i == OFS_IRQ_ST);

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      cond_q <= '0;
    end else begin
      cond_q <= cond;
    end
  end

  // Onset sets the bit; a set in the clearing cycle wins
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      irq_st_q <= IRQ_ST_RST;
    end else begin
      irq_st_q <= (irq_st_q & ~(wr_irq_st ? reg_wdata_i[EV_W-1:0] : '0)) | (cond & ~cond_q);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_st_q & irq_msk_q);
    end
  end

  assign irq_o = irq_q;

  // ********
  // Register port
  // ********
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      mute_q    <= CTRL_MUTE_RST;
      irq_msk_q <= IRQ_MSK_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == OFS_CTRL) begin
        mute_q <= reg_wdata_i[CTRL_MUTE_BIT];
      end
      if (reg_addr_i == OFS_IRQ_MSK) begin
        irq_msk_q <= reg_wdata_i[EV_W-1:0];
      end
    end
  end

  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (reg_addr_i)
      OFS_CTRL:    rdata_d[CTRL_MUTE_BIT] = mute_q;
      OFS_STATE: begin
        rdata_d[ST_CODE_LSB +: 3]    = code;
        rdata_d[ST_MODE_LSB +: 2]    = mode;
        rdata_d[ST_EV_LSB +: EV_W]   = cond;
        rdata_d[ST_PD_N_BIT]         = pd_n;
        rdata_d[ST_RST_N_BIT]        = dev_rst_n;
      end
      OFS_IRQ_ST:  rdata_d[EV_W-1:0] = irq_st_q;
      OFS_IRQ_MSK: rdata_d[EV_W-1:0] = irq_msk_q;
      OFS_LINES:   rdata_d[2:0]      = lines;
      default:     rdata_d           = 32'h0000_0000;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= reg_rd_i ? rdata_d : 32'h0000_0000;
    end
  end

  assign reg_rdata_o = rdata_q;

endmodule : hbfc_top

`default_nettype wire

/* test/hbfc_mod_model.sv */
`timescale 1ns/1ps
`default_nettype none

module hbfc_mod_model #(
  parameter int unsigned RST_HOLD_CYC = 40_000  // Reset hold, clocks
) (
  input  wire logic       mclk_i,        // Clock
  input  wire logic       nrst_i,        // Sync reset, active low
  input  wire logic       valid_i,       // Modulator output valid
  input  wire logic       a_i,           // Wanted level A
  input  wire logic       b_i,           // Wanted level B
  input  wire logic       bad_i,         // Equal pair levels
  input  wire logic [2:0] oe_n_i,        // Fault line enables
  output logic            pwm_a_pos_o,   // PWM A(+)
  output logic            pwm_a_neg_o,   // PWM A(-)
  output logic            pwm_b_pos_o,   // PWM B(+)
  output logic            pwm_b_neg_o,   // PWM B(-)
  output logic            dev_reset_n_o, // Device reset
  output logic [2:0]      line_o         // Fault line levels
);
  logic [15:0] hold_q;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      hold_q <= 16'h0000;
    end else if (hold_q != 16'(RST_HOLD_CYC)) begin
      hold_q <= hold_q + 16'h0001;
    end
  end

  // Reset is kept low until the hold time has run out
  assign dev_reset_n_o = valid_i && (hold_q == 16'(RST_HOLD_CYC));
  assign pwm_a_pos_o   = a_i;
  assign pwm_a_neg_o   = bad_i ? a_i : !a_i;
  assign pwm_b_pos_o   = b_i;
  assign pwm_b_neg_o   = bad_i ? b_i : !b_i;
  // Pull-ups: a released line reads high, never a stale value
  assign line_o        = oe_n_i;
endmodule : hbfc_mod_model

`default_nettype wire

/* test/hbfc_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none

module hbfc_top_sva
  import hbfc_pkg::*;
(
  input wire logic       mclk_i,                 // Clock
  input wire logic       nrst_i,                 // Reset
  input wire logic       power_down_n_i,         // Power-down
  input wire logic       dev_reset_n_i,          // Device reset
  input wire logic       overcur_i,              // Over-current
  input wire logic [7:0] temp_i,                 // Temperature
  input wire logic       regulator_out_a_ok_i,   // Regulator A
  input wire logic       regulator_out_b_ok_i,   // Regulator B
  input wire logic       bridge_out_a_o,         // Bridge A
  input wire logic       bridge_out_a_oe_n_o,    // Bridge A enable
  input wire logic       bridge_out_b_o,         // Bridge B
  input wire logic       bridge_out_b_oe_n_o,    // Bridge B enable
  input wire logic       shutdown_n_o,           // Shutdown level
  input wire logic       shutdown_n_oe_n_o,      // Shutdown enable
  input wire logic       fault_code_bit1_o,      // Bit1 level
  input wire logic       fault_code_bit1_oe_n_o, // Bit1 enable
  input wire logic       fault_code_bit0_o,      // Bit0 level
  input wire logic       fault_code_bit0_oe_n_o  // Bit0 enable
);
  // ****************
  // Helpers
  // ****************
  wire [2:0] code = {shutdown_n_oe_n_o, fault_code_bit1_oe_n_o, fault_code_bit0_oe_n_o};
  wire [1:0] oe   = {bridge_out_a_oe_n_o, bridge_out_b_oe_n_o};
  wire [1:0] lvl  = {bridge_out_a_o, bridge_out_b_o};
  wire       live = power_down_n_i && dev_reset_n_i;
  wire       calm = live && !overcur_i;
  wire       ok   = regulator_out_a_ok_i && regulator_out_b_ok_i;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  // Six cycles cover the pin synchronisers and both register stages
  sequence pd_held;    !power_down_n_i [*6]; endsequence
  sequence rst_held;   (power_down_n_i && !dev_reset_n_i) [*6]; endsequence
  sequence short_held; (live && overcur_i) [*6]; endsequence
  sequence short_on;   (live [*4]) ##0 (code == 3'b001); endsequence

  chk_pd_hiz_out: assert property (pd_held |-> oe == 2'b11)
    else $error("bridges driven in power-down");
  chk_pd_lines_free: assert property (pd_held |-> code == 3'b111)
    else $error("fault lines pulled in power-down");
  chk_rst_low_out: assert property (rst_held |-> oe == 2'b00 && lvl == 2'b00)
    else $error("bridges not low in reset");
  chk_lines_od_only: assert property ({shutdown_n_o, fault_code_bit1_o, fault_code_bit0_o} == 3'b000)
    else $error("fault line driven high");
  chk_short_sets_latch: assert property (short_held |-> oe == 2'b11 && code == 3'b001)
    else $error("short not reported");
  chk_short_latch_holds: assert property (short_on |=> code == 3'b001 && oe == 2'b11)
    else $error("short latch lost");
  chk_uv_drives_low: assert property ((calm && !ok) [*6] ##0 code != 3'b001 |->
    code == 3'b011 && oe == 2'b00 && lvl == 2'b00)
    else $error("low regulator not handled");
  chk_ot_drives_low: assert property ((calm && ok && temp_i > TEMP_SHUTDOWN_C) [*6] ##0 code != 3'b001 |->
    code == 3'b010 && oe == 2'b00 && lvl == 2'b00)
    else $error("over-temperature not handled");
endmodule : hbfc_top_sva

bind hbfc_top hbfc_top_sva i_sva (.mclk_i, .nrst_i, .power_down_n_i, .dev_reset_n_i, .overcur_i, .temp_i,
  .regulator_out_a_ok_i, .regulator_out_b_ok_i, .bridge_out_a_o, .bridge_out_a_oe_n_o, .bridge_out_b_o,
  .bridge_out_b_oe_n_o, .shutdown_n_o, .shutdown_n_oe_n_o, .fault_code_bit1_o, .fault_code_bit1_oe_n_o,
  .fault_code_bit0_o, .fault_code_bit0_oe_n_o);

`default_nettype wire

/* test/test_hbfc_fault_control.sv */
`timescale 1ns/1ps
`default_nettype none

module test_hbridge_fault_control;
  import hbfc_pkg::*;
  // ****************
  // Wiring
  // ****************
  localparam int HOLD = 40_000;
  logic mclk_i, nrst_i, power_down_n_i, overcur_i, regulator_out_a_ok_i, regulator_out_b_ok_i;
  logic reg_wr_i, reg_rd_i, valid, want_a, want_b, bad, irq_o;
  logic [7:0] temp_i, reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, rd_q;
  logic dev_reset_n_i, pwm_a_pos_i, pwm_a_neg_i, pwm_b_pos_i, pwm_b_neg_i;
  logic bridge_out_a_o, bridge_out_a_oe_n_o, bridge_out_b_o, bridge_out_b_oe_n_o;
  logic shutdown_n_i, shutdown_n_o, shutdown_n_oe_n_o, fault_code_bit1_i, fault_code_bit1_o;
  logic fault_code_bit1_oe_n_o, fault_code_bit0_i, fault_code_bit0_o, fault_code_bit0_oe_n_o;
  wire [2:0] line;
  wire [3:0] br = {bridge_out_a_oe_n_o, bridge_out_b_oe_n_o, bridge_out_a_o, bridge_out_b_o};
  int error_cnt = 0;
  int check_count = 0;

  assign {shutdown_n_i, fault_code_bit1_i, fault_code_bit0_i} = line;

  hbfc_top i_dut (.*);

  hbfc_mod_model #(.RST_HOLD_CYC(HOLD)) i_mod (.mclk_i, .nrst_i, .valid_i(valid), .a_i(want_a),
    .b_i(want_b), .bad_i(bad), .oe_n_i({shutdown_n_oe_n_o, fault_code_bit1_oe_n_o, fault_code_bit0_oe_n_o}),
    .pwm_a_pos_o(pwm_a_pos_i), .pwm_a_neg_o(pwm_a_neg_i), .pwm_b_pos_o(pwm_b_pos_i),
    .pwm_b_neg_o(pwm_b_neg_i), .dev_reset_n_o(dev_reset_n_i), .line_o(line));

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // ****************
  // Shared tasks
  // ****************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Pin effects need four edges, so polling starts after five
  task automatic wait_lines(input logic [2:0] exp, input int lim);
    int i;
    cyc(5);
    check_count++;
    for (i = 0; i < lim; i++) begin
      if (line === exp) break;
      cyc(1);
    end
    if (i == lim) begin
      error_cnt++;
      $display("[ERR] fault lines expected %b seen %b", exp, line);
      give_verdict();
    end
  endtask : wait_lines

  task automatic reg_write(input logic [7:0] ad, input logic [31:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] ad, output logic [31:0] d);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : reg_read
  // ****************
  // Scenarios
  // ****************
  task automatic t_start();
    cyc(10);
    chk("bridges in reset", 32'h0, 32'(br));
    cyc(HOLD);
    @(posedge mclk_i) {want_a, want_b} <= 2'b10;
    wait_lines(3'b111, 10);
    chk("bridges 10", 32'h2, 32'(br));
    @(posedge mclk_i) {want_a, want_b} <= 2'b01;
    wait_lines(3'b111, 10);
    chk("bridges 01", 32'h1, 32'(br));
    reg_read(OFS_STATE, rd_q);
    chk("state", 32'h0003_0037, rd_q);
    $display("start done");
  endtask : t_start

  task automatic t_regs();
    reg_read(8'h14, rd_q);
    chk("unmapped", 32'h0, rd_q);
    reg_write(OFS_IRQ_MSK, 32'hFFFF_FFFF);
    reg_read(OFS_IRQ_MSK, rd_q);
    chk("mask", 32'h1F, rd_q);
    reg_write(OFS_LINES, 32'h0);
    reg_read(OFS_LINES, rd_q);
    chk("lines reg", 32'h7, rd_q);
    reg_write(OFS_IRQ_MSK, 32'h0);
    reg_write(OFS_CTRL, 32'h1);
    cyc(5);
    chk("bridges muted", 32'h0, 32'(br));
    reg_read(OFS_CTRL, rd_q);
    chk("ctrl", 32'h1, rd_q);
    reg_write(OFS_CTRL, 32'h0);
    cyc(5);
    chk("bridges unmuted", 32'h1, 32'(br));
    $display("registers done");
  endtask : t_regs

  task automatic t_illegal();
    @(posedge mclk_i) bad <= 1'b1;
    wait_lines(3'b000, 10);
    chk("bridges 00", 32'h0, 32'(br));
    @(posedge mclk_i) want_a <= 1'b1;
    wait_lines(3'b000, 10);
    @(posedge mclk_i) {want_a, bad} <= 2'b00;
    wait_lines(3'b111, 10);
    chk("bridges back", 32'h1, 32'(br));
    $display("illegal done");
  endtask : t_illegal

  task automatic t_temp();
    logic [7:0] tv [6] = '{8'h82, 8'h96, 8'h97, 8'h8C, 8'h7E, 8'h7D};
    logic [2:0] ev [6] = '{3'b110, 3'b110, 3'b010, 3'b010, 3'b010, 3'b111};
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk_i) temp_i <= tv[i];
      wait_lines(ev[i], 10);
      chk("bridges temp", ev[i][2] ? 32'h1 : 32'h0, 32'(br));
      cyc(2);
    end
    $display("temperature done");
  endtask : t_temp

  task automatic t_uv();
    reg_write(OFS_IRQ_ST, 32'h1F);
    @(posedge mclk_i) regulator_out_a_ok_i <= 1'b0;
    wait_lines(3'b011, 10);
    chk("bridges uv", 32'h0, 32'(br));
    reg_read(OFS_IRQ_ST, rd_q);
    chk("status uv", 32'h8, rd_q);
    chk("irq masked", 32'h0, 32'(irq_o));
    reg_write(OFS_IRQ_MSK, 32'h8);
    cyc(2);
    chk("irq raised", 32'h1, 32'(irq_o));
    reg_write(OFS_IRQ_ST, 32'h8);
    cyc(2);
    chk("irq cleared", 32'h0, 32'(irq_o));
    @(posedge mclk_i) {regulator_out_a_ok_i, regulator_out_b_ok_i} <= 2'b10;
    wait_lines(3'b011, 10);
    @(posedge mclk_i) regulator_out_b_ok_i <= 1'b1;
    wait_lines(3'b111, 10);
    chk("bridges resumed", 32'h1, 32'(br));
    $display("regulator done");
  endtask : t_uv

  task automatic t_short();
    @(posedge mclk_i) overcur_i <= 1'b1;
    wait_lines(3'b001, 10);
    cyc(2);
    chk("enables short", 32'h3, 32'(br[3:2]));
    @(posedge mclk_i) {overcur_i, regulator_out_a_ok_i} <= 2'b00;
    wait_lines(3'b001, 10);
    chk("enables kept", 32'h3, 32'(br[3:2]));
    reg_read(OFS_IRQ_ST, rd_q);
    chk("status short", 32'h9, rd_q);
    @(posedge mclk_i) {regulator_out_a_ok_i, valid} <= 2'b10;
    wait_lines(3'b111, 10);
    chk("bridges reset", 32'h0, 32'(br));
    @(posedge mclk_i) {want_a, bad} <= 2'b11;
    wait_lines(3'b111, 10);
    chk("pwm ignored", 32'h0, 32'(br));
    @(posedge mclk_i) {want_a, bad, valid} <= 3'b001;
    wait_lines(3'b111, 10);
    chk("bridges after reset", 32'h1, 32'(br));
    $display("short done");
  endtask : t_short

  task automatic t_stall();
    @(posedge mclk_i) {want_a, want_b} <= 2'b10;
    cyc(3900);
    chk("lines before stall", 32'h7, 32'(line));
    wait_lines(3'b000, 200);
    chk("bridges stalled", 32'h0, 32'(br));
    @(posedge mclk_i) {want_a, want_b} <= 2'b01;
    wait_lines(3'b111, 10);
    $display("stall done");
  endtask : t_stall

  task automatic t_pd();
    @(posedge mclk_i) {power_down_n_i, valid, bad, regulator_out_a_ok_i} <= 4'b0010;
    wait_lines(3'b111, 10);
    chk("enables pd", 32'h3, 32'(br[3:2]));
    cyc(3);
    @(posedge mclk_i) {power_down_n_i, valid, bad, regulator_out_a_ok_i} <= 4'b1101;
    wait_lines(3'b111, 10);
    chk("bridges after pd", 32'h1, 32'(br));
    $display("power-down done");
  endtask : t_pd

  initial begin
    {nrst_i, power_down_n_i, overcur_i, regulator_out_a_ok_i, regulator_out_b_ok_i} = 5'b01011;
    {reg_wr_i, reg_rd_i, valid, want_a, want_b, bad} = 6'b001010;
    temp_i = 8'h19;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0000_0000;
    repeat (5) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_start();
    t_regs();
    t_illegal();
    t_temp();
    t_uv();
    t_short();
    t_stall();
    t_pd();
    give_verdict();
  end
endmodule : test_hbridge_fault_control

`default_nettype wire
